// *** include/sync_serial_frame_engine_params.svh ***
// Constants for the synchronous serial frame engine.
// What this block does
// - Polarity zero or message: idle clock low
// - Polarity one: idle clock high, select high
// - Master drives clock pad; slave leaves it off
// - Master start: select low, output enabled
// - Phase one: data and first edge after half
// - Polarity zero phase one: sample falling edges
// - Polarity one phase one: sample rising edges
// - Phase zero: data half, clock edge later
// - Select rises one period after last capture
// - Phase one: select held low between words
// - Phase zero: select pulses high between words
// - Message: 8 control bits, wait, response bits
// - Message start loads shifter, MSB out immediately
// - Message: control on rising, response latched rising
// - Message single: select rises, word delivered
// - Message back-to-back: next control follows directly
// - Slave samples leading edges in phase zero, trailing in phase one, rising in message
// - Words are 4 to 16 bits, MSB first
// - Phase selects first or second capture edge
`ifndef SYNC_SERIAL_FRAME_ENGINE_PARAMS_SVH
`define SYNC_SERIAL_FRAME_ENGINE_PARAMS_SVH

`define DATA_W 16
`define MIN_BITS 5'h04
`define MAX_BITS 5'h10
`define CTRL_BITS 6'h08
`define CLK_PERIOD_NS 20
`define BIT_CLK_PERIOD_NS 160
`define HALF_PERIOD_CYC ((`BIT_CLK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** include/sync_serial_pkg.sv ***
// Types shared by the synchronous serial frame engine.
`default_nettype none
package sync_serial_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_GAP   = 4'h4,
    ST_SLAVE = 4'h8
  } state_t;
endpackage
`default_nettype wire

// *** rtl/sync_serial_frame_engine.sv ***
// Serial frame engine: SPI-style master and slave, message-format master and slave.
`default_nettype none
`include "sync_serial_frame_engine_params.svh"
module sync_serial_frame_engine
  import sync_serial_pkg::*;
#(
  parameter int unsigned HALF_PERIOD = `HALF_PERIOD_CYC
) (
  // Clock, reset and clock enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Configuration
  input wire logic port_enable_i,
  input wire logic master_mode_i,
  input wire logic msg_format_i,
  input wire logic clock_polarity_bit_i,
  input wire logic clock_phase_bit_i,
  input wire logic [4:0] data_bits_i,
  // Transmit word
  input wire logic tx_valid_i,
  input wire logic [`DATA_W-1:0] tx_data_i,
  output logic tx_pop_o,
  // Receive word and status
  output logic rx_valid_o,
  output logic [`DATA_W-1:0] rx_data_o,
  output logic busy_o,
  // Serial pins
  input wire logic serial_bit_clock_i,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe_o,
  input wire logic frame_select_i,
  output logic frame_select_o,
  output logic frame_select_oe_o,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  input wire logic serial_in_i
);

  localparam int unsigned W = `DATA_W;
  localparam int unsigned DIV_W = (HALF_PERIOD > 1) ? $clog2(HALF_PERIOD) : 1;
  localparam logic [5:0] CTRL_STEPS = 6'(`CTRL_BITS * 2);

  state_t state;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [5:0] step;
  logic [4:0] bit_cnt;
  logic [W-1:0] tx_shift;
  logic [W-1:0] rx_shift;
  logic sck_meta, sck_s, sck_d;
  logic fss_meta, fss_s, fss_d;
  logic sin_meta, sin_s;

  logic pol, cpha, msg;
  logic [4:0] nb;
  logic [5:0] two_nb, step_n, last_samp, cont_step, end_step;
  logic [W-1:0] tx_aligned, slv_word, rx_next;
  logic in_toggle, is_change, is_sample, is_cont, start;
  logic sck_edge, lead, trail, s_sample, s_change;

  // Half-period tick that paces every master step.
  assign tick = clk_en_i && (div_cnt == DIV_W'(HALF_PERIOD - 1));

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div_cnt <= '0;
    end else if (clk_en_i) begin
      if (state == ST_IDLE || state == ST_SLAVE || tick) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // Pin inputs pass two flip-flops; the third stage is only for edge detection.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sck_meta <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      fss_meta <= 1'b1;
      fss_s <= 1'b1;
      fss_d <= 1'b1;
      sin_meta <= 1'b0;
      sin_s <= 1'b0;
    end else if (clk_en_i) begin
      sck_meta <= serial_bit_clock_i;
      sck_s <= sck_meta;
      sck_d <= sck_s;
      fss_meta <= frame_select_i;
      fss_s <= fss_meta;
      fss_d <= fss_s;
      sin_meta <= serial_in_i;
      sin_s <= sin_meta;
    end
  end

  // Pad enables for clock and select follow the master/slave choice.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      serial_bit_clock_oe_o <= 1'b0;
      frame_select_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      serial_bit_clock_oe_o <= master_mode_i;
      frame_select_oe_o <= master_mode_i;
    end
  end

  assign msg = msg_format_i;
  assign cpha = clock_phase_bit_i;
  assign pol = msg ? 1'b0 : clock_polarity_bit_i;

  always_comb begin
    nb = data_bits_i;
    if (data_bits_i < `MIN_BITS) begin
      nb = `MIN_BITS;
    end else if (data_bits_i > `MAX_BITS) begin
      nb = `MAX_BITS;
    end
  end

  assign two_nb = {nb, 1'b0};
  assign step_n = step + 6'h01;
  assign last_samp = msg ? two_nb + CTRL_STEPS + 6'h01 : two_nb;
  assign cont_step = msg ? two_nb + CTRL_STEPS + 6'h02 : two_nb + 6'h01;
  assign end_step = msg ? two_nb + CTRL_STEPS + 6'h03 : two_nb + 6'h02;
  // Words are left-aligned so the MSB always leaves from the top bit.
  assign tx_aligned = msg ? {tx_data_i[7:0], 8'h00} : (tx_data_i << (`MAX_BITS - nb));
  assign slv_word = tx_valid_i ? tx_aligned : '0;
  assign rx_next = {rx_shift[W-2:0], sin_s};

  // Master step classes; step counts half periods since select fell, restarting at each back-to-back word.
  always_comb begin
    if (msg) begin
      in_toggle = (step_n <= cont_step);
      is_change = !step_n[0] && (step_n <= CTRL_STEPS);
      is_sample = step_n[0] && (step_n >= CTRL_STEPS + 6'h03) && (step_n <= last_samp);
    end else begin
      in_toggle = cpha ? (step_n <= two_nb) : (step_n >= 6'h02 && step_n <= cont_step);
      is_change = step_n[0] && (step_n < two_nb);
      is_sample = !step_n[0] && (step_n <= two_nb);
    end
  end

  assign is_cont = (step_n == cont_step) && port_enable_i && master_mode_i && tx_valid_i
                   && (msg || cpha);
  assign start = (state == ST_IDLE) && clk_en_i && port_enable_i && master_mode_i
                 && tx_valid_i;

  // Slave edge classes taken from the synchronised link clock.
  assign sck_edge = sck_s != sck_d;
  assign lead = sck_edge && (sck_d == pol);
  assign trail = sck_edge && (sck_d != pol);
  assign s_sample = msg ? (sck_edge && sck_s) : (cpha ? trail : lead);
  assign s_change = !msg && (cpha ? lead : trail);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      step <= '0;
      bit_cnt <= '0;
      tx_shift <= '0;
      rx_shift <= '0;
      tx_pop_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
      busy_o <= 1'b0;
      serial_bit_clock_o <= 1'b0;
      frame_select_o <= 1'b1;
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      tx_pop_o <= 1'b0;
      rx_valid_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          serial_bit_clock_o <= pol;
          frame_select_o <= 1'b1;
          serial_out_o <= 1'b0;
          serial_out_oe_o <= 1'b0;
          busy_o <= 1'b0;
          if (port_enable_i && !master_mode_i) begin
            state <= ST_SLAVE;
          end else if (start) begin
            state <= ST_RUN;
            step <= '0;
            busy_o <= 1'b1;
            frame_select_o <= 1'b0;
            serial_out_oe_o <= 1'b1;
            tx_pop_o <= 1'b1;
            rx_shift <= '0;
            if (msg) begin
              serial_out_o <= tx_aligned[W-1];
              tx_shift <= tx_aligned << 1;
            end else begin
              tx_shift <= tx_aligned;
            end
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (is_cont) begin
              // Next word starts without releasing select.
              step <= msg ? 6'h00 : 6'h01;
              serial_bit_clock_o <= !serial_bit_clock_o;
              serial_out_o <= tx_aligned[W-1];
              tx_shift <= tx_aligned << 1;
              tx_pop_o <= 1'b1;
              rx_shift <= '0;
              if (msg) begin
                rx_valid_o <= 1'b1;
                rx_data_o <= rx_shift;
              end
            end else if (step_n == end_step) begin
              state <= ST_GAP;
              frame_select_o <= 1'b1;
              serial_out_o <= 1'b0;
              serial_out_oe_o <= 1'b0;
              serial_bit_clock_o <= pol;
              if (msg) begin
                rx_valid_o <= 1'b1;
                rx_data_o <= rx_shift;
              end
            end else begin
              step <= step_n;
              if (in_toggle) begin
                serial_bit_clock_o <= !serial_bit_clock_o;
              end
              if (is_change) begin
                serial_out_o <= tx_shift[W-1];
                tx_shift <= tx_shift << 1;
              end
              if (is_sample) begin
                rx_shift <= rx_next;
                if (!msg && step_n == two_nb) begin
                  rx_valid_o <= 1'b1;
                  rx_data_o <= rx_next;
                end
              end
            end
          end
        end
        ST_GAP: begin
          // Select stays high for a half period before any new word.
          if (tick) begin
            state <= ST_IDLE;
          end
        end
        ST_SLAVE: begin
          serial_bit_clock_o <= pol;
          frame_select_o <= 1'b1;
          if (!port_enable_i || master_mode_i) begin
            state <= ST_IDLE;
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
            busy_o <= 1'b0;
          end else if (fss_d && !fss_s) begin
            busy_o <= 1'b1;
            bit_cnt <= '0;
            rx_shift <= '0;
            tx_pop_o <= tx_valid_i;
            serial_out_oe_o <= !msg;
            if (!cpha || msg) begin
              serial_out_o <= slv_word[W-1];
              tx_shift <= slv_word << 1;
            end else begin
              tx_shift <= slv_word;
            end
          end else if (fss_s) begin
            busy_o <= 1'b0;
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
          end else begin
            // A phase-zero word is locked until select is released.
            if (s_sample && bit_cnt < nb) begin
              rx_shift <= rx_next;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == 5'(nb - 5'h01)) begin
                rx_valid_o <= 1'b1;
                rx_data_o <= rx_next;
              end
            end
            if (s_change) begin
              if (cpha && bit_cnt == nb) begin
                serial_out_o <= slv_word[W-1];
                tx_shift <= slv_word << 1;
                tx_pop_o <= tx_valid_i;
                bit_cnt <= '0;
                rx_shift <= '0;
              end else begin
                serial_out_o <= tx_shift[W-1];
                tx_shift <= tx_shift << 1;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  sequence s_run_tick_at(logic [5:0] n);
    state == ST_RUN && tick && step == n && !msg;
  endsequence

  AST_IDLE_LEVELS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $past(state == ST_IDLE && clk_en_i && !start)
    |-> (serial_bit_clock_o == $past(pol) && frame_select_o && !serial_out_o))
    else $error("Idle line levels are wrong.");

  AST_CLK_PAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ($past(clk_en_i) && !$past(sys_rst_i)) |-> serial_bit_clock_oe_o == $past(master_mode_i))
    else $error("Clock pad enable does not follow master mode.");

  AST_START: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    start |=> (!frame_select_o && serial_out_oe_o && tx_pop_o && state == ST_RUN))
    else $error("Master start did not select and enable output.");

  AST_PH1_FIRST_EDGE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_run_tick_at(6'h00) and cpha)
    |=> (serial_bit_clock_o != $past(serial_bit_clock_o)
         && serial_out_o == $past(tx_shift[W-1])))
    else $error("Phase one first edge or data missing.");

  AST_SAMPLE_LEVEL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state == ST_RUN && tick && is_sample && !msg && step_n != end_step)
    |=> serial_bit_clock_o == ($past(cpha) ? $past(pol) : !$past(pol)))
    else $error("Sample taken on the wrong clock edge.");

  AST_PH0_DATA_FIRST: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_run_tick_at(6'h00) and !cpha)
    |=> (serial_bit_clock_o == $past(serial_bit_clock_o)
         && serial_out_o == $past(tx_shift[W-1])))
    else $error("Phase zero clock moved before data.");

  AST_PH0_EDGE_SECOND: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_run_tick_at(6'h01) and !cpha)
    |=> serial_bit_clock_o != $past(serial_bit_clock_o))
    else $error("Phase zero first edge missing.");

  AST_RELEASE_STEP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ($rose(frame_select_o) && $past(state == ST_RUN))
    |-> $past(step_n) == $past(end_step))
    else $error("Select released at the wrong step.");

  AST_PH1_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (tx_pop_o && $past(state == ST_RUN))
    |-> (!frame_select_o && $past(cpha || msg)))
    else $error("Back-to-back word loaded without held select.");

  AST_SELECT_FALL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $fell(frame_select_o) |-> $past(state == ST_IDLE))
    else $error("Select fell outside an idle start.");

  AST_MSG_MSB: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (start && msg) |=> (serial_out_o == $past(tx_data_i[7]) && !frame_select_o))
    else $error("Control MSB not on the line at select fall.");

  AST_MSG_DELIVER: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ($rose(frame_select_o) && $past(state == ST_RUN && msg)) |-> rx_valid_o)
    else $error("Message word not delivered at select release.");

  AST_MSG_CONT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state == ST_RUN && tick && is_cont && msg)
    |=> (rx_valid_o && tx_pop_o && !frame_select_o && !serial_bit_clock_o))
    else $error("Back-to-back message handover wrong.");

endmodule
`default_nettype wire

// *** testbench/serial_peer_model.sv ***
// Behavioural off-chip serial peer that answers the frame engine in master mode.
`default_nettype none
module serial_peer_model (
  // Serial pins seen from the peer
  input wire logic sclk_i,
  input wire logic frame_select_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Mode and reply word
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic msg_i,
  input wire logic [4:0] nbits_i,
  input wire logic [15:0] reply_i,
  output logic [15:0] got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] shreg;
  logic lead;
  int bits;
  int rises;
  initial begin
    miso_o = 1'b0;
    got_o = 16'h0000;
    shreg = 16'h0000;
    bits = 0;
    rises = 0;
  end
  always @(negedge frame_select_n_i) begin
    shreg = reply_i << (16 - nbits_i);
    bits = 0;
    rises = 0;
    if (!msg_i && !pha_i) begin
      miso_o = shreg[15];
      shreg = shreg << 1;
    end
  end
  // A released line shows the inverse of its last level.
  always @(posedge frame_select_n_i) miso_o = ~miso_o;
  always @(sclk_i) begin
    lead = (sclk_i != pol_i);
    if (!frame_select_n_i && msg_i) begin
      if (lead) begin
        rises++;
        if (rises <= 8) got_o = {got_o[14:0], mosi_i};
      end else if (rises == nbits_i + 9) begin
        // Response done: release the line and get ready for a chained control byte.
        rises = 0;
        shreg = reply_i << (16 - nbits_i);
        miso_o = ~miso_o;
      end else if (rises >= 9) begin
        miso_o = shreg[15];
        shreg = shreg << 1;
      end
    end else if (!frame_select_n_i) begin
      if (lead == !pha_i) begin
        got_o = {got_o[14:0], mosi_i};
        bits++;
        if (bits == nbits_i) begin
          bits = 0;
          shreg = reply_i << (16 - nbits_i);
        end
      end else begin
        miso_o = shreg[15];
        shreg = shreg << 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/sync_serial_frame_engine_bench.sv ***
// Self-checking bench for the serial frame engine in master and slave roles.
`default_nettype none
module sync_serial_frame_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic port_enable = 1'b0;
  logic master_mode = 1'b1;
  logic msg_format = 1'b0;
  logic pol = 1'b0;
  logic pha = 1'b1;
  logic [4:0] data_bits = 5'h08;
  logic tx_valid = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic sck = 1'b0;
  logic fs_in_n = 1'b1;
  logic si = 1'b0;
  logic [15:0] reply = 16'hB2E7;
  logic tx_pop, rx_valid, busy, sck_o, sck_oe, fs_o, fs_oe, so, so_oe, miso;
  logic [15:0] rx_data, got, mask, seen;
  logic [15:0] txq [2] = '{16'hA5C3, 16'h3C96};
  logic [15:0] last_rx = 16'h0000;
  logic start_ok = 1'b0;
  logic fs_prev = 1'b1;
  logic [4:0] pol_tab = 5'h06;
  logic [4:0] pha_tab = 5'h05;
  logic [4:0] msg_tab = 5'h18;
  logic [4:0] bits_tab [5] = '{5'h04, 5'h10, 5'h08, 5'h10, 5'h04};
  int cnt_tab [5] = '{2, 2, 2, 1, 2};
  int rise_tab [5] = '{1, 2, 1, 1, 1};
  int qi = 0;
  int qn = 0;
  int rx_cnt = 0;
  int fs_rises = 0;
  int failures = 0;
  int n_compared = 0;
  initial begin
    forever #10 mclk = ~mclk;
  end
  sync_serial_frame_engine #(.HALF_PERIOD(4)) i_dut (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .clk_en_i(clk_en),
    .port_enable_i(port_enable), .master_mode_i(master_mode), .msg_format_i(msg_format),
    .clock_polarity_bit_i(pol), .clock_phase_bit_i(pha), .data_bits_i(data_bits),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_pop_o(tx_pop),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy),
    .serial_bit_clock_i(sck), .serial_bit_clock_o(sck_o), .serial_bit_clock_oe_o(sck_oe),
    .frame_select_i(fs_in_n), .frame_select_o(fs_o), .frame_select_oe_o(fs_oe),
    .serial_out_o(so), .serial_out_oe_o(so_oe), .serial_in_i(master_mode ? miso : si)
  );
  serial_peer_model i_peer (
    .sclk_i(sck_o), .frame_select_n_i(fs_o), .mosi_i(so), .miso_o(miso),
    .pol_i(pol), .pha_i(pha), .msg_i(msg_format), .nbits_i(data_bits),
    .reply_i(reply), .got_o(got)
  );
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      last_rx <= rx_data;
      rx_cnt <= rx_cnt + 1;
    end
    if (fs_o === 1'b1 && fs_prev === 1'b0) fs_rises <= fs_rises + 1;
    fs_prev <= fs_o;
  end
  always @(negedge mclk) begin
    if (tx_pop === 1'b1) begin
      if (qi == 0) start_ok <= (fs_o === 1'b0 && so_oe === 1'b1);
      qi = qi + 1;
      tx_valid <= (qi < qn);
      tx_data <= txq[qi % 2];
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] val);
    n_compared++;
    if (val !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, val);
      failures++;
    end
  endtask
  task setup(input logic m, input logic f, input logic p, input logic h, input logic [4:0] n);
    @(negedge mclk);
    master_mode = m;
    msg_format = f;
    pol = p;
    pha = h;
    data_bits = n;
    repeat (4) @(negedge mclk);
  endtask
  task idle(input logic lvl);
    chk("idle clock", 16'(lvl), 16'(sck_o));
    chk("idle select", 16'h0001, 16'(fs_o));
    chk("idle data", 16'h0000, 16'(so));
    chk("clock pad", 16'(master_mode), 16'(sck_oe));
    chk("select pad", 16'(master_mode), 16'(fs_oe));
    chk("idle busy", 16'h0000, 16'(busy));
  endtask
  task launch(input int cnt);
    fs_rises = 0;
    rx_cnt = 0;
    start_ok = 1'b0;
    qi = 0;
    qn = cnt;
    tx_data = txq[0];
    tx_valid = 1'b1;
    // Freeze the engine for a few cycles early in the frame; the transfer must still complete.
    repeat (10) @(negedge mclk);
    clk_en = 1'b0;
    chk("busy", 16'h0001, 16'(busy));
    repeat (7) @(negedge mclk);
    clk_en = 1'b1;
    for (int k = 0; k < 4000 && rx_cnt < cnt; k++) @(posedge mclk);
    repeat (30) @(negedge mclk);
    chk("rx count", 16'(cnt), 16'(rx_cnt));
  endtask
  task slave_frame(input logic [15:0] w, input int n);
    seen = 16'h0000;
    @(negedge mclk);
    fs_in_n = 1'b0;
    #240;
    for (int i = n - 1; i >= 0; i--) begin
      si = w[i];
      #80;
      sck = 1'b1;
      #79;
      seen = {seen[14:0], so};
      #1;
      sck = 1'b0;
    end
    #160;
    fs_in_n = 1'b1;
    #200;
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    tx_valid = 1'b1;
    repeat (40) @(negedge mclk);
    chk("pop while disabled", 16'h0000, 16'(qi));
    tx_valid = 1'b0;
    port_enable = 1'b1;
    $display("test disabled done");
    for (int t = 0; t < 5; t++) begin
      setup(1'b1, msg_tab[t], pol_tab[t], pha_tab[t], bits_tab[t]);
      idle(pol_tab[t]);
      launch(cnt_tab[t]);
      mask = 16'hFFFF >> (16 - bits_tab[t]);
      chk("start", 16'h0001, 16'(start_ok));
      chk("rx word", reply & mask, last_rx);
      if (msg_tab[t]) chk("control", {8'h00, txq[cnt_tab[t] - 1][7:0]}, {8'h00, got[7:0]});
      else chk("peer word", txq[cnt_tab[t] - 1] & mask, got & mask);
      chk("select rises", 16'(rise_tab[t]), 16'(fs_rises));
      idle(pol_tab[t]);
      $display("test mode %0d done", t);
    end
    setup(1'b0, 1'b0, 1'b0, 1'b0, 5'h08);
    idle(1'b0);
    rx_cnt = 0;
    qi = 0;
    qn = 1;
    tx_data = txq[1];
    tx_valid = 1'b1;
    slave_frame(16'h005A, 8);
    chk("slave rx", 16'h005A, last_rx);
    chk("slave tx", txq[1] & 16'h00FF, seen);
    $display("test slave done");
    setup(1'b0, 1'b1, 1'b0, 1'b0, 5'h08);
    slave_frame(16'h00C3, 8);
    chk("message slave rx", 16'h00C3, last_rx);
    $display("test message slave done");
    complete_run;
  end
endmodule
`default_nettype wire
